// ### hdl/rsps_pkg.sv
// constants and types for the reset and standby pin sequencer
package rsps_pkg;
  localparam int CLK_PERIOD_PS = 10000;
  // address bus goes low 2.5 clock periods after the low reset is sampled
  localparam int ADDR_LOW_DELAY_PS = 25000;
  // least time rounds up to whole cycles
  localparam int ADDR_LOW_CYC = (ADDR_LOW_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] ADDR_LOW_LAST = 2'(ADDR_LOW_CYC - 1);
  // reset must lead standby by this many cycles when memory is retained
  localparam int RET_LEAD_CYC = 10;
  // reset must lead standby release by about this time
  localparam int RECOVERY_LEAD_NS = 100;
  localparam int RECOVERY_LEAD_CYC = (RECOVERY_LEAD_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [3:0] RET_LEAD_CNT = 4'(RET_LEAD_CYC);
  localparam logic [3:0] RECOVERY_LEAD_CNT = 4'(RECOVERY_LEAD_CYC);
  localparam logic [3:0] LEAD_CNT_MAX = 4'hf;
  // reset values
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic PIN_LEVEL_IDLE = 1'b1;
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [7:0] PORT_RESET = 8'h00;
  // operating mode codes on i_mode
  localparam logic [1:0] MODE_1 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h1;
  localparam logic [1:0] MODE_3 = 2'h2;
  localparam logic [1:0] MODE_4 = 2'h3;
  // field positions
  localparam int ADDR_TOP_LSB = 21;
  localparam int SYNC_INIT_BIT = 0;
  localparam int SYNC_SLEEP_BIT = 1;

  typedef enum logic [1:0] {
    RSPS_RUN = 2'b00,
    RSPS_RST_WAIT = 2'b01,
    RSPS_RST_ADDR_LOW = 2'b10
  } rsps_phase_e;
endpackage : rsps_pkg

// ### hdl/rsps_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module rsps_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } rsps_sync_s;

  rsps_sync_s st_q;
  rsps_sync_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = i_pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // a change counts only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st_q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
    end else if (i_clk_en) begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.lvl;
endmodule : rsps_sync
`default_nettype wire

// ### hdl/rsps_top.sv
// reset and standby pin sequencer: pin states around the external reset input
`timescale 1ns/1ps
`default_nettype none
module rsps_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_system_init_low_n,
  input wire logic i_hw_sleep_request_n,
  input wire logic [1:0] i_mode,
  input wire logic i_onchip_memory_enable,
  input wire logic [2:0] i_top_addr_line_enable,
  input wire logic [3:0] i_upper_select_enable,
  input wire logic i_clk_out_stop,
  input wire logic i_hold_pins,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_data,
  input wire logic i_data_drive,
  input wire logic i_address_strobe_n,
  input wire logic i_read_strobe_n,
  input wire logic i_upper_byte_write_n,
  input wire logic i_lower_byte_write_n,
  input wire logic i_area_zero_select_n,
  input wire logic [3:0] i_upper_select_n,
  input wire logic [7:0] i_port_out,
  input wire logic [7:0] i_port_dir,
  input wire logic [2:0] i_top_port_out,
  input wire logic [2:0] i_top_port_dir,
  input wire logic [3:0] i_sel_port_out,
  input wire logic [3:0] i_sel_port_dir,
  output logic [20:0] o_addr,
  output logic o_addr_oe,
  output logic [2:0] o_top_pin,
  output logic [2:0] o_top_pin_oe,
  output logic [3:0] o_sel_pin,
  output logic [3:0] o_sel_pin_oe,
  output logic [15:0] o_data,
  output logic [15:0] o_data_oe,
  output logic o_address_strobe_n,
  output logic o_read_strobe_n,
  output logic o_upper_byte_write_n,
  output logic o_lower_byte_write_n,
  output logic o_area_zero_select_n,
  output logic [7:0] o_port,
  output logic [7:0] o_port_oe,
  output logic o_clk_pin_oe,
  output logic o_in_reset,
  output logic o_sequence_fault
);
  typedef struct packed {
    rsps_pkg::rsps_phase_e phase;
    logic [1:0] dly_cnt;
    logic [3:0] lead_cnt;
    logic sleep_prev;
    logic fault;
    logic clk_oe;
    logic [23:0] addr;
    logic addr_oe;
    logic [2:0] top_oe;
    logic [3:0] sel_oe;
    logic [15:0] data;
    logic data_oe;
    logic as_n;
    logic rd_n;
    logic hw_n;
    logic lw_n;
    logic cs0_n;
    logic [3:0] sel;
    logic [2:0] top;
    logic [7:0] port;
    logic [7:0] port_oe;
  } rsps_state_s;

  rsps_state_s st_q;
  rsps_state_s st_d;
  logic [1:0] sync_lvl;
  logic init_low;
  logic sleep_n;
  logic wide_mode;
  logic [2:0] top_is_addr;

  rsps_sync #(
    .W(2),
    .INIT(2'h3)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_pin({i_hw_sleep_request_n, i_system_init_low_n}),
    .o_level(sync_lvl)
  );

  assign init_low = ~sync_lvl[rsps_pkg::SYNC_INIT_BIT];
  assign sleep_n = sync_lvl[rsps_pkg::SYNC_SLEEP_BIT];
  assign wide_mode = (i_mode == rsps_pkg::MODE_3) || (i_mode == rsps_pkg::MODE_4);
  assign top_is_addr = wide_mode ? ~i_top_addr_line_enable : 3'h0;

  always_comb begin
    st_d = st_q;
    // reset phase sequencing
    case (st_q.phase)
      rsps_pkg::RSPS_RUN: begin
        if (init_low) begin
          st_d.phase = rsps_pkg::RSPS_RST_WAIT;
          st_d.dly_cnt = 2'h0;
        end
      end
      rsps_pkg::RSPS_RST_WAIT: begin
        if (!init_low) begin
          st_d.phase = rsps_pkg::RSPS_RUN;
        end else if (st_q.dly_cnt == rsps_pkg::ADDR_LOW_LAST) begin
          st_d.phase = rsps_pkg::RSPS_RST_ADDR_LOW;
        end else begin
          st_d.dly_cnt = st_q.dly_cnt + 2'h1;
        end
      end
      rsps_pkg::RSPS_RST_ADDR_LOW: begin
        if (!init_low) begin
          st_d.phase = rsps_pkg::RSPS_RUN;
        end
      end
      default: begin
        st_d.phase = rsps_pkg::RSPS_RUN;
      end
    endcase

    // the pin is read raw here so the clock output starts on the very next edge
    st_d.clk_oe = ~i_system_init_low_n | ~i_clk_out_stop;

    if (st_q.phase != rsps_pkg::RSPS_RUN) begin
      st_d.as_n = rsps_pkg::STROBE_IDLE;
      st_d.rd_n = rsps_pkg::STROBE_IDLE;
      st_d.hw_n = rsps_pkg::STROBE_IDLE;
      st_d.lw_n = rsps_pkg::STROBE_IDLE;
      st_d.cs0_n = rsps_pkg::STROBE_IDLE;
      st_d.data_oe = 1'b0;
      st_d.port_oe = 8'h00;
      st_d.top_oe = 3'h0;
      st_d.sel_oe = 4'h0;
      st_d.addr_oe = 1'b1;
      if (st_q.phase == rsps_pkg::RSPS_RST_ADDR_LOW || st_d.phase == rsps_pkg::RSPS_RST_ADDR_LOW) begin
        st_d.addr = rsps_pkg::ADDR_RESET;
      end
    end else if (!i_hold_pins) begin
      st_d.addr = i_addr;
      st_d.addr_oe = 1'b1;
      st_d.data = i_data;
      st_d.data_oe = i_data_drive;
      st_d.as_n = i_address_strobe_n;
      st_d.rd_n = i_read_strobe_n;
      st_d.hw_n = i_upper_byte_write_n;
      st_d.lw_n = i_lower_byte_write_n;
      st_d.cs0_n = i_area_zero_select_n;
      st_d.port = i_port_out;
      st_d.port_oe = i_port_dir;
      for (int i = 0; i < 3; i++) begin
        st_d.top[i] = top_is_addr[i] ? i_addr[rsps_pkg::ADDR_TOP_LSB + i] : i_top_port_out[i];
        st_d.top_oe[i] = top_is_addr[i] | i_top_port_dir[i];
      end
      for (int i = 0; i < 4; i++) begin
        st_d.sel[i] = i_upper_select_enable[i] ? i_upper_select_n[i] : i_sel_port_out[i];
        st_d.sel_oe[i] = i_upper_select_enable[i] | i_sel_port_dir[i];
      end
    end else begin
      // held: driven values freeze, anything not driven stays floating
      st_d.port_oe = st_q.port_oe;
    end

    // supervisor ordering watch; the fault flag is sticky until module reset
    st_d.sleep_prev = sleep_n;
    if (!init_low) begin
      st_d.lead_cnt = 4'h0;
    end else if (st_q.lead_cnt != rsps_pkg::LEAD_CNT_MAX) begin
      st_d.lead_cnt = st_q.lead_cnt + 4'h1;
    end
    // reset released before standby falls leaves the lead at zero, so it lands here too
    if (st_q.sleep_prev && !sleep_n && i_onchip_memory_enable &&
        (st_q.lead_cnt < rsps_pkg::RET_LEAD_CNT)) begin
      st_d.fault = 1'b1;
    end
    if (!st_q.sleep_prev && sleep_n && (st_q.lead_cnt < rsps_pkg::RECOVERY_LEAD_CNT)) begin
      st_d.fault = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st_q <= '{
        phase: rsps_pkg::RSPS_RUN,
        dly_cnt: 2'h0,
        lead_cnt: 4'h0,
        sleep_prev: rsps_pkg::PIN_LEVEL_IDLE,
        fault: 1'b0,
        clk_oe: 1'b0,
        addr: rsps_pkg::ADDR_RESET,
        addr_oe: 1'b0,
        top_oe: 3'h0,
        sel_oe: 4'h0,
        data: rsps_pkg::DATA_RESET,
        data_oe: 1'b0,
        as_n: rsps_pkg::STROBE_IDLE,
        rd_n: rsps_pkg::STROBE_IDLE,
        hw_n: rsps_pkg::STROBE_IDLE,
        lw_n: rsps_pkg::STROBE_IDLE,
        cs0_n: rsps_pkg::STROBE_IDLE,
        sel: 4'hf,
        top: 3'h0,
        port: rsps_pkg::PORT_RESET,
        port_oe: rsps_pkg::PORT_RESET
      };
    end else if (i_clk_en) begin
      st_q <= st_d;
    end
  end

  // the raw pin gates these asynchronously: the pins must react before any edge
  assign o_port_oe = st_q.port_oe & {8{i_system_init_low_n}};
  assign o_top_pin_oe = st_q.top_oe & {3{i_system_init_low_n}};
  assign o_sel_pin_oe = st_q.sel_oe & {4{i_system_init_low_n}};
  assign o_data_oe = {16{st_q.data_oe & i_system_init_low_n}};
  assign o_address_strobe_n = st_q.as_n | ~i_system_init_low_n;
  assign o_read_strobe_n = st_q.rd_n | ~i_system_init_low_n;
  assign o_upper_byte_write_n = st_q.hw_n | ~i_system_init_low_n;
  assign o_lower_byte_write_n = st_q.lw_n | ~i_system_init_low_n;
  assign o_area_zero_select_n = st_q.cs0_n | ~i_system_init_low_n;
  assign o_addr = st_q.addr[20:0];
  assign o_addr_oe = st_q.addr_oe;
  assign o_top_pin = st_q.top;
  assign o_sel_pin = st_q.sel;
  assign o_data = st_q.data;
  assign o_port = st_q.port;
  assign o_clk_pin_oe = st_q.clk_oe;
  assign o_in_reset = (st_q.phase != rsps_pkg::RSPS_RUN);
  assign o_sequence_fault = st_q.fault;
endmodule : rsps_top
`default_nettype wire

// ### tb/rsps_supervisor.sv
// reset and standby supervisor model driving the two external pins
`timescale 1ns/1ps
`default_nettype none
module rsps_supervisor (
  input wire logic i_sys_clk,
  output var logic o_init_n,
  output var logic o_sleep_n
);
  initial begin
    o_init_n = 1'b1;
    o_sleep_n = 1'b1;
  end
  task automatic set_init(input logic v);
    @(posedge i_sys_clk);
    o_init_n <= v;
  endtask : set_init
  // a lead under ten cycles breaks the retention order on purpose
  task automatic enter_standby(input int lead, input logic use_rst);
    if (use_rst) set_init(1'b0);
    repeat (lead) @(posedge i_sys_clk);
    o_sleep_n <= 1'b0;
    @(posedge i_sys_clk);
    o_init_n <= 1'b1;
  endtask : enter_standby
  task automatic leave_standby();
    set_init(1'b0);
    // 120 ns lead over the release
    repeat (12) @(posedge i_sys_clk);
    o_sleep_n <= 1'b1;
    repeat (12) @(posedge i_sys_clk);
    o_init_n <= 1'b1;
  endtask : leave_standby
endmodule : rsps_supervisor
`default_nettype wire

// ### tb/rsps_top_properties.sv
// port assertions for the reset and standby pin sequencer
`timescale 1ns/1ps
`default_nettype none
module rsps_top_properties (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_system_init_low_n,
  input wire logic i_hold_pins,
  input wire logic [1:0] i_mode,
  input wire logic [2:0] i_top_addr_line_enable,
  input wire logic [23:0] i_addr,
  input wire logic [20:0] o_addr,
  input wire logic o_addr_oe,
  input wire logic [2:0] o_top_pin,
  input wire logic [2:0] o_top_pin_oe,
  input wire logic [3:0] o_sel_pin_oe,
  input wire logic [15:0] o_data_oe,
  input wire logic [7:0] o_port,
  input wire logic [7:0] o_port_oe,
  input wire logic o_address_strobe_n,
  input wire logic o_read_strobe_n,
  input wire logic o_upper_byte_write_n,
  input wire logic o_lower_byte_write_n,
  input wire logic o_area_zero_select_n,
  input wire logic o_clk_pin_oe,
  input wire logic o_in_reset,
  input wire logic o_sequence_fault
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  wire logic rp = !i_system_init_low_n;
  wire logic st = &{o_address_strobe_n, o_read_strobe_n, o_upper_byte_write_n,
    o_lower_byte_write_n, o_area_zero_select_n};
  chk_port_input: assert property (rp |-> o_port_oe == 8'h00)
    else $error("port driven while reset pin low");
  chk_bus_idle: assert property (rp |-> o_data_oe == 16'h0000 && st)
    else $error("bus not idle while reset pin low");
  chk_wide_float: assert property (rp |-> o_top_pin_oe == 3'h0 && o_sel_pin_oe == 4'h0)
    else $error("upper pins driven while reset pin low");
  chk_addr_low: assert property ($rose(o_in_reset) |-> ##3 o_addr == 21'h0 && o_addr_oe)
    else $error("address not low on time");
  chk_clk_start: assert property (rp |=> o_clk_pin_oe)
    else $error("clock pin not driving");
  chk_sync_lag: assert property (rp [*6] |-> o_in_reset)
    else $error("reset not taken");
  chk_top_addr: assert property ((!rp && !o_in_reset && !$past(o_in_reset) && !i_hold_pins
    && i_mode == rsps_pkg::MODE_3 && i_top_addr_line_enable == 3'h0)
    |=> o_top_pin == $past(i_addr[23:21]))
    else $error("top pins not carrying address");
  chk_hold_keep: assert property ((i_hold_pins && !rp && !o_in_reset) |=> $stable(o_port))
    else $error("held port changed");
  chk_fault_sticky: assert property (o_sequence_fault |=> o_sequence_fault)
    else $error("fault flag dropped");
  cover property ($rose(o_in_reset));
  cover property ($rose(o_sequence_fault));
  cover property (i_hold_pins && !o_in_reset);
endmodule : rsps_top_properties
bind rsps_top rsps_top_properties u_props (.*);
`default_nettype wire

// ### tb/rsps_top_test.sv
// self-checking bench for the reset and standby pin sequencer
`timescale 1ns/1ps
`default_nettype none
module rsps_top_test;
  logic i_sys_clk, i_rst_b, i_clk_en, i_onchip_memory_enable, i_clk_out_stop, i_hold_pins;
  logic i_data_drive, i_address_strobe_n, i_read_strobe_n, i_upper_byte_write_n;
  logic i_lower_byte_write_n, i_area_zero_select_n, o_addr_oe, o_address_strobe_n;
  logic o_read_strobe_n, o_upper_byte_write_n, o_lower_byte_write_n, o_area_zero_select_n;
  logic o_clk_pin_oe, o_in_reset, o_sequence_fault;
  logic [1:0] i_mode;
  logic [2:0] i_top_addr_line_enable, i_top_port_out, i_top_port_dir, o_top_pin, o_top_pin_oe;
  logic [3:0] i_upper_select_enable, i_upper_select_n, i_sel_port_out, i_sel_port_dir;
  logic [3:0] o_sel_pin, o_sel_pin_oe;
  logic [23:0] i_addr;
  logic [15:0] i_data, o_data, o_data_oe;
  logic [7:0] i_port_out, i_port_dir, o_port, o_port_oe;
  logic [20:0] o_addr;
  wire logic i_system_init_low_n, i_hw_sleep_request_n;
  int n_mismatch = 0;
  int compares = 0;
  rsps_supervisor sup (.i_sys_clk(i_sys_clk), .o_init_n(i_system_init_low_n),
    .o_sleep_n(i_hw_sleep_request_n));
  rsps_top dut (.*);
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : cyc
  task automatic summarize();
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic t_run();
    cyc(1);
    i_mode <= rsps_pkg::MODE_3;
    i_upper_select_enable <= 4'hf;
    i_addr <= 24'hc00001;
    i_upper_select_n <= 4'h5;
    i_data <= 16'h5aa5;
    {i_port_dir, i_port_out, i_data_drive} <= {8'hff, 8'h3c, 1'b1};
    {i_address_strobe_n, i_read_strobe_n, i_upper_byte_write_n, i_lower_byte_write_n,
      i_area_zero_select_n} <= 5'h00;
    cyc(3);
    #1 chk({o_top_pin, o_top_pin_oe}, 6'h37);
    chk(o_sel_pin, 4'h5);
    chk(o_data, 16'h5aa5);
    chk(o_data_oe, 16'hffff);
    cyc(1);
    {i_top_addr_line_enable, i_top_port_out, i_top_port_dir} <= 9'h1d7;
    {i_upper_select_enable, i_sel_port_out, i_sel_port_dir} <= 12'h0af;
    cyc(3);
    #1 chk(o_top_pin, 3'h2);
    chk(o_sel_pin, 4'ha);
  endtask : t_run
  task automatic t_hold();
    cyc(1);
    i_hold_pins <= 1'b1;
    i_port_out <= 8'hc3;
    cyc(3);
    #1 chk({o_port, o_port_oe}, 16'h3cff);
    cyc(1);
    i_hold_pins <= 1'b0;
    cyc(3);
    #1 chk(o_port, 8'hc3);
  endtask : t_hold
  task automatic t_rst();
    int k;
    k = 0;
    sup.set_init(1'b0);
    #1 chk(o_port_oe, 8'h00);
    chk({o_data_oe, o_address_strobe_n, o_read_strobe_n, o_upper_byte_write_n,
      o_lower_byte_write_n, o_area_zero_select_n}, 21'h1f);
    chk({o_top_pin_oe, o_sel_pin_oe}, 7'h00);
    chk(o_clk_pin_oe, 1'b0);
    cyc(1);
    #1 chk(o_clk_pin_oe, 1'b1);
    while (o_in_reset !== 1'b1 && k < 20) begin
      cyc(1);
      #1 k++;
    end
    chk(o_in_reset, 1'b1);
    cyc(2);
    #1 chk(o_addr, 21'h1);
    cyc(1);
    #1 chk({o_addr_oe, o_addr}, 22'h200000);
    sup.set_init(1'b1);
    cyc(8);
  endtask : t_rst
  task automatic t_standby();
    cyc(1);
    i_onchip_memory_enable <= 1'b1;
    sup.enter_standby(10, 1'b1);
    sup.leave_standby();
    cyc(5);
    #1 chk(o_sequence_fault, 1'b0);
    sup.enter_standby(3, 1'b1);
    sup.leave_standby();
    cyc(5);
    #1 chk(o_sequence_fault, 1'b1);
    cyc(1);
    i_rst_b <= 1'b0;
    i_onchip_memory_enable <= 1'b0;
    cyc(2);
    i_rst_b <= 1'b1;
    sup.enter_standby(2, 1'b0);
    sup.leave_standby();
    cyc(5);
    #1 chk(o_sequence_fault, 1'b0);
  endtask : t_standby
  initial begin
    {i_rst_b, i_clk_en, i_onchip_memory_enable, i_clk_out_stop, i_hold_pins} = 5'h0a;
    {i_address_strobe_n, i_read_strobe_n, i_upper_byte_write_n, i_lower_byte_write_n,
      i_area_zero_select_n, i_data_drive} = 6'h3e;
    {i_mode, i_top_addr_line_enable, i_upper_select_enable, i_upper_select_n} = 13'h00f;
    {i_top_port_out, i_top_port_dir, i_sel_port_out, i_sel_port_dir} = 14'h0;
    {i_addr, i_data, i_port_out, i_port_dir} = 56'h0;
    cyc(10);
    i_rst_b <= 1'b1;
    t_run();
    t_hold();
    t_rst();
    t_standby();
    summarize();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #50us;
    n_mismatch++;
    summarize();
  end
endmodule : rsps_top_test
`default_nettype wire
